/* gain_clip_pkg.sv */
// constants, field layouts and carrier types for the gain and clip control register bank
package gain_clip_pkg;
  // register offsets on the control port
  localparam logic [6:0] ADDR_GAIN_FIRST_LEFT = 7'h01;
  localparam logic [6:0] ADDR_GAIN_FIRST_RIGHT = 7'h02;
  localparam logic [6:0] ADDR_GAIN_SECOND_LEFT = 7'h03;
  localparam logic [6:0] ADDR_GAIN_SECOND_RIGHT = 7'h04;
  localparam logic [6:0] ADDR_GAIN_CLIP_CONTROL = 7'h05;
  localparam logic [6:0] ADDR_FIRST_ADC_LEFT_SEL = 7'h06;
  localparam int NUM_CHANNELS = 4;

  // reset values
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] GAIN_CLIP_CONTROL_RESET = 8'h86;
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h41;

  // gain range, 7.1 two's complement (half-dB steps)
  localparam logic signed [7:0] GAIN_MIN = 8'shE8;
  localparam logic signed [7:0] GAIN_MAX = 8'sh50;
  localparam logic signed [7:0] GAIN_STEP = 8'sh01;

  // attenuation limits in half-dB codes: -3, -4, -5, -6 dB
  localparam logic [7:0] ATT_LIMIT_3DB = 8'hFA;
  localparam logic [7:0] ATT_LIMIT_4DB = 8'hF8;
  localparam logic [7:0] ATT_LIMIT_5DB = 8'hF6;
  localparam logic [7:0] ATT_LIMIT_6DB = 8'hF4;

  // clip detections before suppression starts
  localparam logic [6:0] TRIGGER_80 = 7'h50;
  localparam logic [6:0] TRIGGER_40 = 7'h28;
  localparam logic [6:0] TRIGGER_20 = 7'h14;
  localparam logic [6:0] TRIGGER_10 = 7'h0A;

  // input select codes
  localparam logic [5:0] SELECT_NONE = 6'h00;

  // smooth gain change: one half-dB step per interval
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CNT_W = 6;

  // control port framing
  localparam logic [4:0] BITS_PER_FRAME = 5'h10;
  localparam logic [4:0] ADDR_BITS = 5'h08;

  typedef struct packed {
    logic ramp_enable;
    logic gang_enable;
    logic post_digital_clip_detect_enable;
    logic [1:0] suppression_attenuation_limit;
    logic [1:0] suppression_trigger_count;
    logic clip_suppression_enable;
  } gain_clip_control_t;

  typedef struct packed {
    logic input_invert;
    logic reserved_bit;
    logic [5:0] first_adc_left;
  } input_select_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_in_t;

  typedef struct packed {
    logic suppression_active;
    logic [7:0] attenuation_limit;
  } suppression_t;

  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_ADDR = 2'b01,
    PORT_DATA = 2'b10
  } port_state_t;
endpackage

/* gain_clip_ctrl.sv */
// gain, ganging, clip suppression and input select register bank behind the serial control port
`timescale 1ns/1ps

// Overview of operation
// - each gain register is 8-bit two's complement, one fractional bit, half-dB steps.
// - applied gain codes span 0xE8 (-12 dB) to 0x50 (+40 dB).
// - all four gain registers reset to zero, meaning 0 dB.
// - gain is analog plus digital, analog only when manual mapping is on.
// - gains sit at 0x01..0x04: first left, first right, second left, second right.
// - bit 7 set ramps gain gradually (reset value); cleared applies it immediately.
// - gang bit makes the other three channels follow first-left gain; reset off.
// - post-digital clip detection works only while bit 5 is set; reset off.
// - attenuation limit field 00..11 gives -3, -4, -5, -6 dB; reset 00.
// - trigger field 00..11 means 80, 40, 20, 10 detections; reset 11.
// - clipping suppression runs only while bit 0 is set; reset off.
// - control register 0x05 resets to 0x86.
// - register 0x06 holds invert bit 7, reserved bit 6, select 5..0; reset 0x41.
// - invert bit set flips polarity of the selected first-ADC left input.
// - select code 1 picks first single-ended left input, code 0 picks none.
module gain_clip_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // serial control port pins
  input wire gain_clip_pkg::spi_in_t spi_in,
  output logic spi_miso,
  output logic spi_miso_oe,
  // gain mapping mode and clip events from the datapath
  input wire logic manual_gain_map,
  input wire logic clip_event,
  // applied gains, channel order as the register order
  output logic [gain_clip_pkg::NUM_CHANNELS-1:0][7:0] applied_gain,
  output logic gain_analog_only,
  // clip handling
  output logic clip_detect_active,
  output gain_clip_pkg::suppression_t suppression,
  // first-ADC left input routing
  output logic [5:0] first_adc_left_select,
  output logic first_adc_left_none,
  output logic first_adc_left_invert
);

  function automatic logic [7:0] clamp_gain(input logic [7:0] code);
    if ($signed(code) < gain_clip_pkg::GAIN_MIN) begin
      clamp_gain = gain_clip_pkg::GAIN_MIN;
    end else if ($signed(code) > gain_clip_pkg::GAIN_MAX) begin
      clamp_gain = gain_clip_pkg::GAIN_MAX;
    end else begin
      clamp_gain = code;
    end
  endfunction

  function automatic logic [6:0] trigger_threshold(input logic [1:0] field);
    case (field)
      2'b00: trigger_threshold = gain_clip_pkg::TRIGGER_80;
      2'b01: trigger_threshold = gain_clip_pkg::TRIGGER_40;
      2'b10: trigger_threshold = gain_clip_pkg::TRIGGER_20;
      default: trigger_threshold = gain_clip_pkg::TRIGGER_10;
    endcase
  endfunction

  function automatic logic [7:0] attenuation_code(input logic [1:0] field);
    case (field)
      2'b00: attenuation_code = gain_clip_pkg::ATT_LIMIT_3DB;
      2'b01: attenuation_code = gain_clip_pkg::ATT_LIMIT_4DB;
      2'b10: attenuation_code = gain_clip_pkg::ATT_LIMIT_5DB;
      default: attenuation_code = gain_clip_pkg::ATT_LIMIT_6DB;
    endcase
  endfunction

  // pin synchronisers; stage one feeds stage two only
  gain_clip_pkg::spi_in_t pin_meta_q;
  gain_clip_pkg::spi_in_t pin_sync_q;
  gain_clip_pkg::spi_in_t pin_last_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      pin_sync_q <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      pin_last_q <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    end else begin
      pin_meta_q <= spi_in;
      pin_sync_q <= pin_meta_q;
      pin_last_q <= pin_sync_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  assign selected = !pin_sync_q.cs_n;
  assign sclk_rise = selected && pin_sync_q.sclk && !pin_last_q.sclk;
  assign sclk_fall = selected && !pin_sync_q.sclk && pin_last_q.sclk;

  // frame: 7-bit address, read flag, then data bytes with auto-increment
  gain_clip_pkg::port_state_t port_state_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_in_q;
  logic [7:0] shift_out_q;
  logic [6:0] addr_q;
  logic read_q;
  logic wr_strobe_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] shift_next;
  assign shift_next = {shift_in_q[6:0], pin_sync_q.mosi};

  // stored registers
  logic [gain_clip_pkg::NUM_CHANNELS-1:0][7:0] gain_q;
  gain_clip_pkg::gain_clip_control_t control_q;
  gain_clip_pkg::input_select_t input_sel_q;

  function automatic logic [7:0] read_reg(input logic [6:0] addr);
    case (addr)
      gain_clip_pkg::ADDR_GAIN_FIRST_LEFT: read_reg = gain_q[0];
      gain_clip_pkg::ADDR_GAIN_FIRST_RIGHT: read_reg = gain_q[1];
      gain_clip_pkg::ADDR_GAIN_SECOND_LEFT: read_reg = gain_q[2];
      gain_clip_pkg::ADDR_GAIN_SECOND_RIGHT: read_reg = gain_q[3];
      gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL: read_reg = control_q;
      gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL: read_reg = input_sel_q;
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_state_q <= gain_clip_pkg::PORT_IDLE;
      bit_cnt_q <= 5'h00;
      shift_in_q <= 8'h00;
      addr_q <= 7'h00;
      read_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_strobe_q <= 1'b0;
      case (port_state_q)
        gain_clip_pkg::PORT_IDLE: begin
          bit_cnt_q <= 5'h00;
          if (selected) begin
            port_state_q <= gain_clip_pkg::PORT_ADDR;
          end
        end
        gain_clip_pkg::PORT_ADDR: begin
          if (!selected) begin
            port_state_q <= gain_clip_pkg::PORT_IDLE;
          end else if (sclk_rise) begin
            shift_in_q <= shift_next;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q + 5'h01 == gain_clip_pkg::ADDR_BITS) begin
              addr_q <= shift_next[7:1];
              read_q <= shift_next[0];
              port_state_q <= gain_clip_pkg::PORT_DATA;
            end
          end
        end
        gain_clip_pkg::PORT_DATA: begin
          if (!selected) begin
            port_state_q <= gain_clip_pkg::PORT_IDLE;
          end else if (sclk_rise) begin
            shift_in_q <= shift_next;
            if (bit_cnt_q + 5'h01 == gain_clip_pkg::BITS_PER_FRAME) begin
              bit_cnt_q <= gain_clip_pkg::ADDR_BITS;
              addr_q <= addr_q + 7'h01;
              wr_strobe_q <= !read_q;
              wr_addr_q <= addr_q;
              wr_data_q <= shift_next;
            end else begin
              bit_cnt_q <= bit_cnt_q + 5'h01;
            end
          end
        end
        default: port_state_q <= gain_clip_pkg::PORT_IDLE;
      endcase
    end
  end

  // read data: loaded as each data byte starts, shifted out on falling clock
  logic load_out;
  assign load_out = (port_state_q == gain_clip_pkg::PORT_ADDR && sclk_rise &&
    bit_cnt_q + 5'h01 == gain_clip_pkg::ADDR_BITS) ||
    (port_state_q == gain_clip_pkg::PORT_DATA && sclk_rise &&
    bit_cnt_q + 5'h01 == gain_clip_pkg::BITS_PER_FRAME);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_out_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= selected && read_q && port_state_q == gain_clip_pkg::PORT_DATA;
      if (load_out) begin
        shift_out_q <= (port_state_q == gain_clip_pkg::PORT_ADDR) ?
          read_reg(shift_next[7:1]) : read_reg(addr_q + 7'h01);
      end else if (sclk_fall && port_state_q == gain_clip_pkg::PORT_DATA) begin
        spi_miso <= shift_out_q[7];
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // register writes; followers keep their own stored value while ganged
  genvar ch;
  generate
    for (ch = 0; ch < gain_clip_pkg::NUM_CHANNELS; ch++) begin : g_gain_reg
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          gain_q[ch] <= gain_clip_pkg::GAIN_RESET;
        end else if (wr_strobe_q &&
            wr_addr_q == gain_clip_pkg::ADDR_GAIN_FIRST_LEFT + 7'(ch)) begin
          gain_q[ch] <= wr_data_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      control_q <= gain_clip_pkg::GAIN_CLIP_CONTROL_RESET;
      input_sel_q <= gain_clip_pkg::INPUT_SELECT_RESET;
    end else if (wr_strobe_q) begin
      if (wr_addr_q == gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL) begin
        control_q <= wr_data_q;
      end
      // bit 6 is stored as written; the host keeps it at one
      if (wr_addr_q == gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL) begin
        input_sel_q <= wr_data_q;
      end
    end
  end

  // per-channel target and smooth/immediate gain application
  logic [gain_clip_pkg::NUM_CHANNELS-1:0][7:0] target;
  localparam int RAMP_W = gain_clip_pkg::RAMP_CNT_W;
  logic [RAMP_W-1:0] ramp_cnt_q;
  localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(gain_clip_pkg::RAMP_STEP_CYCLES - 1);
  logic ramp_tick;
  assign ramp_tick = (ramp_cnt_q == RAMP_LAST);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ramp_cnt_q <= '0;
    end else begin
      ramp_cnt_q <= ramp_tick ? '0 : ramp_cnt_q + RAMP_W'(1);
    end
  end

  generate
    for (ch = 0; ch < gain_clip_pkg::NUM_CHANNELS; ch++) begin : g_apply
      // followers use the first-left value only while ganged
      assign target[ch] = clamp_gain(control_q.gang_enable ? gain_q[0] : gain_q[ch]);
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          applied_gain[ch] <= gain_clip_pkg::GAIN_RESET;
        end else if (!control_q.ramp_enable) begin
          applied_gain[ch] <= target[ch];
        end else if (ramp_tick && $signed(applied_gain[ch]) < $signed(target[ch])) begin
          applied_gain[ch] <= applied_gain[ch] + gain_clip_pkg::GAIN_STEP;
        end else if (ramp_tick && $signed(applied_gain[ch]) > $signed(target[ch])) begin
          applied_gain[ch] <= applied_gain[ch] - gain_clip_pkg::GAIN_STEP;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gain_analog_only <= 1'b0;
    end else begin
      gain_analog_only <= manual_gain_map;
    end
  end

  // clip counting and suppression; counter clears whenever either enable drops
  logic [6:0] clip_detection_count_q;
  logic counting;
  assign counting = control_q.post_digital_clip_detect_enable && control_q.clip_suppression_enable;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clip_detection_count_q <= 7'h00;
      clip_detect_active <= 1'b0;
      suppression <= '{suppression_active: 1'b0, attenuation_limit: gain_clip_pkg::ATT_LIMIT_3DB};
    end else begin
      clip_detect_active <= control_q.post_digital_clip_detect_enable;
      suppression.attenuation_limit <=
        attenuation_code(control_q.suppression_attenuation_limit);
      if (!counting) begin
        clip_detection_count_q <= 7'h00;
        suppression.suppression_active <= 1'b0;
      end else if (clip_detection_count_q >=
          trigger_threshold(control_q.suppression_trigger_count)) begin
        suppression.suppression_active <= 1'b1;
      end else if (clip_event) begin
        clip_detection_count_q <= clip_detection_count_q + 7'h01;
      end
    end
  end

  // input routing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      first_adc_left_select <= gain_clip_pkg::INPUT_SELECT_RESET[5:0];
      first_adc_left_none <= 1'b0;
      first_adc_left_invert <= 1'b0;
    end else begin
      first_adc_left_select <= input_sel_q.first_adc_left;
      first_adc_left_none <= input_sel_q.first_adc_left == gain_clip_pkg::SELECT_NONE;
      first_adc_left_invert <= input_sel_q.input_invert;
    end
  end

  AST_GAIN_IN_RANGE: assert property (@(posedge sys_clk) disable iff (!resetn)
    $signed(applied_gain[1]) >= gain_clip_pkg::GAIN_MIN &&
    $signed(applied_gain[1]) <= gain_clip_pkg::GAIN_MAX)
    else $error("applied gain out of range");
  AST_IMMEDIATE_GAIN: assert property (@(posedge sys_clk) disable iff (!resetn)
    !control_q.ramp_enable && $stable(control_q) && $stable(gain_q) |=>
    applied_gain[0] == $past(target[0]))
    else $error("immediate gain change not applied in one cycle");
  AST_RAMP_ONE_STEP: assert property (@(posedge sys_clk) disable iff (!resetn)
    control_q.ramp_enable && !ramp_tick |=> $stable(applied_gain[2]))
    else $error("ramped gain moved off a step tick");
  AST_GANG_FOLLOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    control_q.gang_enable |-> target[3] == clamp_gain(gain_q[0]))
    else $error("ganged channel not following first left");
  AST_WRITE_CONTROL: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_strobe_q && wr_addr_q == gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL |=>
    control_q == $past(wr_data_q))
    else $error("control write not stored");
  AST_CLIP_DISABLED: assert property (@(posedge sys_clk) disable iff (!resetn)
    !control_q.post_digital_clip_detect_enable |=> clip_detection_count_q == 7'h00 &&
    !clip_detect_active)
    else $error("clip counting while detection disabled");
  AST_SUPPRESS_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
    !control_q.clip_suppression_enable |=> !suppression.suppression_active)
    else $error("suppression active while disabled");
  AST_TRIGGER: assert property (@(posedge sys_clk) disable iff (!resetn)
    counting && $stable(control_q) && clip_detection_count_q ==
    trigger_threshold(control_q.suppression_trigger_count) |=> suppression.suppression_active)
    else $error("suppression did not start at trigger count");
  AST_ATT_LIMIT: assert property (@(posedge sys_clk) disable iff (!resetn)
    control_q.suppression_attenuation_limit == 2'b11 |=>
    suppression.attenuation_limit == gain_clip_pkg::ATT_LIMIT_6DB)
    else $error("attenuation limit wrong");
  AST_INVERT: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> first_adc_left_invert == $past(input_sel_q.input_invert))
    else $error("invert output lags register");
  AST_NONE_SELECT: assert property (@(posedge sys_clk) disable iff (!resetn)
    input_sel_q.first_adc_left == 6'h01 |=> !first_adc_left_none)
    else $error("code one decoded as no input");
  AST_ANALOG_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
    manual_gain_map |=> gain_analog_only)
    else $error("analog-only flag missed");
endmodule

/* spi_host_model.sv */
// host side of the serial control port: mode 0 frames, msb first
`timescale 1ns/1ps
module spi_host_model (
  // clock used only to pace the pins
  input wire logic sys_clk,
  // control port pins
  output gain_clip_pkg::spi_in_t spi_in,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // ten system cycles per half bit, well above the four-cycle minimum
  localparam int HALF = 10;

  initial begin
    spi_in = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic start();
    wait_clk(1);
    spi_in.cs_n = 1'b0;
    wait_clk(HALF);
  endtask

  // miso is only trusted while the device says it drives it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_in.mosi = tx[i];
      wait_clk(HALF);
      rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      spi_in.sclk = 1'b1;
      wait_clk(HALF);
      spi_in.sclk = 1'b0;
    end
  endtask

  // released data line shows the inverse of its last level, never a stale copy
  task automatic stop();
    wait_clk(HALF);
    spi_in.cs_n = 1'b1;
    spi_in.mosi = ~spi_in.mosi;
    wait_clk(HALF);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    if (a == gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL) begin
      d[6] = 1'b1;
    end
    start();
    xfer({a, 1'b0}, dummy);
    xfer(d, dummy);
    stop();
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] dummy;
    start();
    xfer({a, 1'b1}, dummy);
    xfer(8'h00, d);
    stop();
  endtask
endmodule

/* gain_clip_ctrl_tb.sv */
// self-checking bench for the gain and clip control register bank
`timescale 1ns/1ps
module gain_clip_ctrl_tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] att;
    logic det;
  } row_t;

  logic sys_clk;
  logic resetn;
  gain_clip_pkg::spi_in_t spi_in;
  logic spi_miso;
  logic spi_miso_oe;
  logic manual_gain_map;
  logic clip_event;
  logic [gain_clip_pkg::NUM_CHANNELS-1:0][7:0] applied_gain;
  logic gain_analog_only;
  logic clip_detect_active;
  gain_clip_pkg::suppression_t suppression;
  logic [5:0] first_adc_left_select;
  logic first_adc_left_none;
  logic first_adc_left_invert;
  int err_count;
  int checks_done;
  int cyc;
  logic [7:0] r;
  logic [7:0] d;
  row_t rows[4];
  int trig[4];

  gain_clip_ctrl uut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .spi_in(spi_in),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .manual_gain_map(manual_gain_map),
    .clip_event(clip_event),
    .applied_gain(applied_gain),
    .gain_analog_only(gain_analog_only),
    .clip_detect_active(clip_detect_active),
    .suppression(suppression),
    .first_adc_left_select(first_adc_left_select),
    .first_adc_left_none(first_adc_left_none),
    .first_adc_left_invert(first_adc_left_invert)
  );

  spi_host_model host (
    .sys_clk(sys_clk),
    .spi_in(spi_in),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      clip_event = 1'b1;
      host.wait_clk(1);
      clip_event = 1'b0;
      host.wait_clk(1);
    end
    host.wait_clk(3);
  endtask

  // generous ceiling: the whole run needs roughly fifteen thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    resetn = 1'b0;
    manual_gain_map = 1'b0;
    clip_event = 1'b0;
    rows = '{'{8'h00, gain_clip_pkg::ATT_LIMIT_3DB, 1'b0},
             '{8'h28, gain_clip_pkg::ATT_LIMIT_4DB, 1'b1},
             '{8'h10, gain_clip_pkg::ATT_LIMIT_5DB, 1'b0},
             '{8'h38, gain_clip_pkg::ATT_LIMIT_6DB, 1'b1}};
    trig = '{80, 40, 20, 10};
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    host.wait_clk(5);
    // reset state of registers and outputs
    for (int a = 1; a <= 4; a++) begin
      host.rd(7'(a), r);
      check(r, 8'h00, "gain reset");
    end
    host.rd(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, r);
    check(r, 8'h86, "control reset");
    host.rd(gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL, r);
    check(r, 8'h41, "select reset");
    check(suppression.attenuation_limit, gain_clip_pkg::ATT_LIMIT_3DB, "att reset");
    check({2'b00, first_adc_left_select}, 8'h01, "select out reset");
    check(first_adc_left_none, 1'b0, "none reset");
    check(clip_detect_active, 1'b0, "detect reset");
    // control field table
    foreach (rows[i]) begin
      host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, rows[i].ctrl);
      host.rd(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, r);
      check(r, rows[i].ctrl, "control readback");
      check(suppression.attenuation_limit, rows[i].att, "att limit");
      check(clip_detect_active, rows[i].det, "detect enable");
    end
    // one burst across all four gains, with out-of-range codes
    host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h00);
    host.start();
    host.xfer({gain_clip_pkg::ADDR_GAIN_FIRST_LEFT, 1'b0}, r);
    host.xfer(8'hE8, r);
    host.xfer(8'h50, r);
    host.xfer(8'h7F, r);
    host.xfer(8'h80, r);
    host.stop();
    check(applied_gain[0], gain_clip_pkg::GAIN_MIN, "ch0 min");
    check(applied_gain[1], gain_clip_pkg::GAIN_MAX, "ch1 max");
    check(applied_gain[2], gain_clip_pkg::GAIN_MAX, "ch2 clamp");
    check(applied_gain[3], gain_clip_pkg::GAIN_MIN, "ch3 clamp");
    host.rd(gain_clip_pkg::ADDR_GAIN_SECOND_LEFT, r);
    check(r, 8'h7F, "stored code");
    // ganging: followers track ch0, stored values survive
    host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h40);
    for (int c = 1; c < 4; c++) begin
      check(applied_gain[c], 8'hE8, "ganged");
    end
    host.rd(gain_clip_pkg::ADDR_GAIN_FIRST_RIGHT, r);
    check(r, 8'h50, "follower kept");
    host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h00);
    check(applied_gain[1], 8'h50, "ungang restore");
    // smooth change takes many steps
    host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h80);
    host.wr(gain_clip_pkg::ADDR_GAIN_FIRST_LEFT, 8'h02);
    check({7'h00, applied_gain[0] == 8'h02}, 8'h00, "ramp not done");
    host.wait_clk(1300);
    check(applied_gain[0], 8'h02, "ramp done");
    // suppression trigger counts
    for (int t = 0; t < 4; t++) begin
      d = 8'h21 | 8'(t << 1);
      host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, d);
      pulses(trig[t] - 1);
      check(suppression.suppression_active, 1'b0, "early");
      pulses(1);
      check(suppression.suppression_active, 1'b1, "trigger");
      host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h20);
      check(suppression.suppression_active, 1'b0, "disabled");
    end
    host.wr(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, 8'h07);
    pulses(10);
    check(suppression.suppression_active, 1'b0, "no detect");
    // input select and polarity
    host.wr(gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL, 8'h80);
    host.rd(gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL, r);
    check(r, 8'hC0, "select readback");
    check(first_adc_left_invert, 1'b1, "invert");
    check(first_adc_left_none, 1'b1, "no input");
    host.wr(gain_clip_pkg::ADDR_FIRST_ADC_LEFT_SEL, 8'h01);
    check(first_adc_left_invert, 1'b0, "normal");
    check({2'b00, first_adc_left_select}, 8'h01, "first input");
    // analog-only mapping and an unmapped read
    manual_gain_map = 1'b1;
    host.wait_clk(2);
    check(gain_analog_only, 1'b1, "analog only");
    manual_gain_map = 1'b0;
    host.wait_clk(2);
    check(gain_analog_only, 1'b0, "combined");
    host.rd(7'h10, r);
    check(r, 8'h00, "unmapped");
    // reset in mid-run: gain ramped to 02 and control at 07 must both fall back
    resetn = 1'b0;
    host.wait_clk(2);
    check(applied_gain[0], gain_clip_pkg::GAIN_RESET, "gain in reset");
    check(suppression.attenuation_limit, gain_clip_pkg::ATT_LIMIT_3DB, "att in reset");
    resetn = 1'b1;
    host.wait_clk(5);
    host.rd(gain_clip_pkg::ADDR_GAIN_CLIP_CONTROL, r);
    check(r, 8'h86, "control after reset");
    host.rd(gain_clip_pkg::ADDR_GAIN_FIRST_LEFT, r);
    check(r, 8'h00, "gain after reset");
    finish_test();
  end
endmodule
